// [common/brs_pkg.sv]
// Overview of operation
// - memory code bits 5:0, reset 101011
// - memory bit 6 switches rail on
// - mode 0: ramp to new code after go
// - mode 1: memory code kept as preset
// - peripheral code bits 4:0, reset 11011, clamp
// - peripheral bit 5 selects half-size pass device
// - peripheral bit 6 reports rail on, read-only
// - peripheral mode 0: code applied at once
// - peripheral mode 1: preset applied at power-down
`default_nettype none
package brs_pkg;

  // ==========================================================
  // register map (index, byte address is four times it)
  localparam logic [7:0] MEM_REG_IDX = 8'h30;
  localparam logic [7:0] PERI_REG_IDX = 8'h31;
  localparam logic [7:0] STAT_REG_IDX = 8'h32;
  localparam int ADDR_IDX_LSB = 2;

  // ==========================================================
  // field positions
  localparam int MEM_CODE_MSB = 5;
  localparam int PERI_CODE_MSB = 4;
  localparam int PERI_HALF_BIT = 5;
  localparam int RAIL_ON_BIT = 6;
  localparam int APPLY_MODE_BIT = 7;

  // ==========================================================
  // reset values and limits
  localparam logic [7:0] MEM_REG_RST = 8'h2b;
  localparam logic [7:0] PERI_REG_RST = 8'h1b;
  localparam logic [5:0] MEM_CODE_RST = 6'h2b;
  localparam logic [4:0] PERI_CODE_RST = 5'h1b;
  localparam logic [4:0] PERI_CODE_MAX = 5'h1e;

  // ==========================================================
  // ramp timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RAMP_CNT_LAST = 4'(RAMP_STEP_CYC - 1);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_MEM = 2'h1,
    SEL_PERI = 2'h2,
    SEL_STAT = 2'h3
  } brs_sel_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'h0,
    RS_WAIT = 2'h1,
    RS_STEP = 2'h3
  } brs_ramp_st_t;

  typedef struct packed {
    logic wr;
    brs_sel_t sel;
    logic [7:0] wdata;
  } brs_req_t;

  typedef struct packed {
    logic on;
    logic [5:0] code;
    logic [5:0] preset;
    logic ramping;
  } brs_mem_out_t;

  typedef struct packed {
    logic on;
    logic halfSize;
    logic [4:0] code;
    logic [4:0] preset;
  } brs_peri_out_t;

  function automatic brs_sel_t brs_decode(input logic [31:0] addr);
    brs_sel_t s;
    s = SEL_NONE;
    if (addr == {22'h0, MEM_REG_IDX, 2'h0}) s = SEL_MEM;
    if (addr == {22'h0, PERI_REG_IDX, 2'h0}) s = SEL_PERI;
    if (addr == {22'h0, STAT_REG_IDX, 2'h0}) s = SEL_STAT;
    return s;
  endfunction : brs_decode

  // codes above the top step give the top voltage
  function automatic logic [4:0] brs_peri_clamp(input logic [4:0] c);
    return (c > PERI_CODE_MAX) ? PERI_CODE_MAX : c;
  endfunction : brs_peri_clamp

endpackage : brs_pkg
`default_nettype wire

// [rtl/brs_ahb_slave.sv]
`default_nettype none
module brs_ahb_slave import brs_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output brs_req_t req,
  input wire logic [7:0] rdata
);
  logic dphWr_r;
  logic dphRd_r;
  logic rdDone_r;
  brs_sel_t dphSel_r;
  logic addrPh;

  assign addrPh = hsel & hready & htrans[1];
  // reads take one wait state so the data always come from a flop
  assign hreadyout = ce & ~(dphRd_r & ~rdDone_r);
  assign hresp = 1'b0;
  assign req.wr = ce & dphWr_r;
  assign req.sel = dphSel_r;
  assign req.wdata = hwdata[7:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dphWr_r <= 1'b0;
      dphRd_r <= 1'b0;
      dphSel_r <= SEL_NONE;
    end else if (ce && hready) begin
      dphWr_r <= addrPh & hwrite;
      dphRd_r <= addrPh & ~hwrite;
      dphSel_r <= addrPh ? brs_decode(haddr) : SEL_NONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdDone_r <= 1'b0;
      hrdata <= 32'h0;
    end else if (ce) begin
      rdDone_r <= dphRd_r & ~rdDone_r;
      if (dphRd_r && !rdDone_r) begin
        hrdata <= {24'h0, rdata};
      end
    end
  end
endmodule : brs_ahb_slave
`default_nettype wire

// [rtl/brs_rail_regs.sv]
// Chosen here: register access over AHB-Lite.
`default_nettype none
module brs_rail_regs import brs_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic memRailRampGo,
  input wire logic periPowerUp,
  input wire logic periPowerDown,
  output brs_mem_out_t memRail,
  output brs_peri_out_t periRail
);
  // ==========================================================
  // bus slave
  brs_req_t req;
  logic [7:0] rdata;
  logic [7:0] memReg_r;
  logic [7:0] periReg_r;
  logic [5:0] memPreset_r;
  logic [5:0] memPendCode_r;
  logic memPend_r;
  logic [4:0] periCode_r;
  logic [4:0] periPreset_r;
  logic periOn_r;
  logic periPresetUsed_r;
  logic rampStart;
  logic rampBusy;
  logic [5:0] rampLevel;
  logic wrMem;
  logic wrPeri;
  logic [7:0] statVal;

  brs_ahb_slave brs_ahb_slave_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .req(req),
    .rdata(rdata)
  );

  // only whole-word transfers are expected; size is not checked
  assign wrMem = req.wr && req.sel == SEL_MEM;
  assign wrPeri = req.wr && req.sel == SEL_PERI;

  // ==========================================================
  // memory rail register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memReg_r <= MEM_REG_RST;
    end else if (ce && wrMem) begin
      memReg_r <= req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memPreset_r <= MEM_CODE_RST;
    end else if (ce && wrMem && req.wdata[APPLY_MODE_BIT]) begin
      memPreset_r <= req.wdata[MEM_CODE_MSB:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memPend_r <= 1'b0;
      memPendCode_r <= MEM_CODE_RST;
    end else if (ce) begin
      if (wrMem && !req.wdata[APPLY_MODE_BIT]) begin
        memPend_r <= 1'b1;
        memPendCode_r <= req.wdata[MEM_CODE_MSB:0];
      end else if (memRailRampGo) begin
        memPend_r <= 1'b0;
      end
    end
  end

  assign rampStart = ce & memRailRampGo & memPend_r;

  brs_ramp brs_ramp_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .start(rampStart),
    .target(memPendCode_r),
    .level(rampLevel),
    .busy(rampBusy)
  );

  assign memRail.on = memReg_r[RAIL_ON_BIT];
  assign memRail.code = rampLevel;
  assign memRail.preset = memPreset_r;
  assign memRail.ramping = rampBusy;

  // ==========================================================
  // peripheral rail register
  // on bit is never taken from the bus
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periReg_r <= PERI_REG_RST;
    end else if (ce && wrPeri) begin
      periReg_r <= {req.wdata[APPLY_MODE_BIT], 1'b0, req.wdata[PERI_HALF_BIT:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periPreset_r <= PERI_CODE_RST;
    end else if (ce && wrPeri && req.wdata[APPLY_MODE_BIT]) begin
      periPreset_r <= brs_peri_clamp(req.wdata[PERI_CODE_MSB:0]);
    end
  end

  // applied code: immediate writes or preset at power-down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periCode_r <= PERI_CODE_RST;
      periPresetUsed_r <= 1'b0;
    end else if (ce) begin
      // clear first so a power-down marking in the same cycle wins
      if (periPowerUp) periPresetUsed_r <= 1'b0;
      if (periPowerDown && periReg_r[APPLY_MODE_BIT]) begin
        periCode_r <= periPreset_r;
        periPresetUsed_r <= 1'b1;
      end else if (wrPeri && !req.wdata[APPLY_MODE_BIT]) begin
        periCode_r <= brs_peri_clamp(req.wdata[PERI_CODE_MSB:0]);
      end
    end
  end

  // on state follows the sequencer, not software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periOn_r <= 1'b0;
    end else if (ce) begin
      if (periPowerUp) periOn_r <= 1'b1;
      else if (periPowerDown && !periReg_r[APPLY_MODE_BIT]) periOn_r <= 1'b0;
    end
  end

  assign periRail.on = periOn_r;
  assign periRail.halfSize = periReg_r[PERI_HALF_BIT];
  assign periRail.code = periCode_r;
  assign periRail.preset = periPreset_r;

  // ==========================================================
  // read mux
  assign statVal = {4'h0, periPresetUsed_r, periOn_r, memPend_r, rampBusy};

  always_comb begin
    case (req.sel)
      SEL_MEM: rdata = memReg_r;
      // live on state in bit 6
      SEL_PERI: rdata = {periReg_r[APPLY_MODE_BIT], periOn_r, periReg_r[PERI_HALF_BIT:0]};
      SEL_STAT: rdata = statVal;
      default: rdata = 8'h0;
    endcase
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_mem_code_write: assert property (
    ce && wrMem |=> memReg_r[MEM_CODE_MSB:0] == $past(req.wdata[MEM_CODE_MSB:0]))
    else $error("memory code not stored");

  a_mem_on_write: assert property (
    ce && wrMem |=> memRail.on == $past(req.wdata[RAIL_ON_BIT]))
    else $error("memory rail on bit not applied");

  a_ramp_needs_go: assert property (
    $rose(rampBusy) |-> $past(memRailRampGo) && $past(memPend_r))
    else $error("ramp started without go");

  a_ramp_go_start: assert property (
    ce && memRailRampGo && memPend_r && !rampBusy |=> rampBusy)
    else $error("go did not start the ramp");

  a_mem_preset_only: assert property (
    ce && wrMem && req.wdata[APPLY_MODE_BIT] && !memRailRampGo
    |=> memPreset_r == $past(req.wdata[MEM_CODE_MSB:0]) && $stable(memPendCode_r))
    else $error("memory preset write touched the rail");

  a_peri_clamp: assert property (
    periRail.code <= PERI_CODE_MAX && periRail.preset <= PERI_CODE_MAX)
    else $error("peripheral code above top step");

  a_peri_half_size: assert property (
    ce && wrPeri |=> periRail.halfSize == $past(req.wdata[PERI_HALF_BIT]))
    else $error("pass size bit not applied");

  a_peri_on_ro: assert property (
    ce && wrPeri && !periPowerUp && !periPowerDown |=> $stable(periOn_r))
    else $error("write changed peripheral on state");

  a_peri_on_status: assert property (
    ce && periPowerUp |=> periRail.on)
    else $error("peripheral on state not reported");

  a_peri_immediate: assert property (
    ce && wrPeri && !periPowerDown && !req.wdata[APPLY_MODE_BIT]
    |=> periRail.code == brs_peri_clamp($past(req.wdata[PERI_CODE_MSB:0])))
    else $error("immediate code not applied");

  a_peri_preset_pd: assert property (
    ce && periPowerDown && !periPowerUp && periReg_r[APPLY_MODE_BIT]
    |=> periRail.code == $past(periPreset_r) && periRail.on == $past(periOn_r))
    else $error("preset not applied at power-down");

  c_mem_ramp: cover property (rampStart ##1 rampBusy [*3]);
  c_mem_preset: cover property (ce && wrMem && req.wdata[APPLY_MODE_BIT]);
  c_peri_pd_preset: cover property (ce && periPowerDown && periReg_r[APPLY_MODE_BIT]);
  c_read_wait: cover property (hsel && htrans[1] && !hwrite && hready ##1 !hreadyout);

endmodule : brs_rail_regs
`default_nettype wire

// [rtl/brs_ramp.sv]
`default_nettype none
module brs_ramp import brs_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [5:0] target,
  output logic [5:0] level,
  output logic busy
);
  brs_ramp_st_t state_r;
  logic [5:0] goal_r;
  logic [3:0] cnt_r;

  assign busy = (state_r != RS_IDLE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RS_IDLE;
      goal_r <= MEM_CODE_RST;
      cnt_r <= 4'h0;
    end else if (ce) begin
      case (state_r)
        RS_IDLE: begin
          if (start) begin
            goal_r <= target;
            cnt_r <= 4'h0;
            state_r <= RS_WAIT;
          end
        end
        RS_WAIT: begin
          // a new go retargets a ramp in flight
          if (start) goal_r <= target;
          if (level == goal_r && !start) state_r <= RS_IDLE;
          else if (cnt_r == RAMP_CNT_LAST) state_r <= RS_STEP;
          else cnt_r <= cnt_r + 4'h1;
        end
        RS_STEP: begin
          cnt_r <= 4'h0;
          state_r <= RS_WAIT;
        end
        default: state_r <= RS_IDLE;
      endcase
    end
  end

  // one code step per step period keeps the rail slew bounded
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level <= MEM_CODE_RST;
    end else if (ce && state_r == RS_STEP) begin
      if (level < goal_r) level <= level + 6'h1;
      else if (level > goal_r) level <= level - 6'h1;
    end
  end
endmodule : brs_ramp
`default_nettype wire

// [tb/tb_brs_rail_regs.sv]
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_brs_rail_regs import brs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [31:0] a; logic [7:0] w; logic [7:0] r;} brs_tb_row_t;

  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic ce = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic memRailRampGo = 1'h0;
  logic periPowerUp = 1'h0;
  logic periPowerDown = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  brs_mem_out_t memRail;
  brs_peri_out_t periRail;
  int n_mismatch = 0;
  int cmp_count = 0;
  int k;
  // bit 6 of the peripheral row reads the live on state, not the written one
  brs_tb_row_t rows [3] = '{
    '{32'hc4, 8'h7f, 8'h3f},
    '{32'hc0, 8'hea, 8'hea},
    '{32'hd0, 8'hff, 8'h00}
  };

  always #50 mclk = ~mclk;

  brs_rail_regs brs_rail_regs_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .memRailRampGo(memRailRampGo),
    .periPowerUp(periPowerUp),
    .periPowerDown(periPowerDown),
    .memRail(memRail),
    .periRail(periRail)
  );

  // ==========================================================
  // closing report
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // bus tasks
  // hready is read at the edge, before that edge's updates land
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      $display("mismatch hreadyout exp 1 got %b", hreadyout);
      finish_test();
    end
  endtask : wait_rdy

  task bus(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    r = hrdata;
  endtask : bus

  task pulse(input int s);
    @(posedge mclk);
    case (s)
      0: memRailRampGo <= 1'b1;
      1: periPowerUp <= 1'b1;
      default: periPowerDown <= 1'b1;
    endcase
    @(posedge mclk);
    {memRailRampGo, periPowerUp, periPowerDown} <= 3'h0;
    #1;
  endtask : pulse

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    `CHK("memCode", 6'h2b, memRail.code)
    `CHK("memOn", 1'b0, memRail.on)
    `CHK("periCode", 5'h1b, periRail.code)
    `CHK("periHalf", 1'b0, periRail.halfSize)
    `CHK("periOn", 1'b0, periRail.on)
    @(posedge mclk);
    bus(1'b0, 32'hc0, 8'h0, rd);
    `CHK("memReg", 32'h2b, rd)
    bus(1'b0, 32'hc4, 8'h0, rd);
    `CHK("periReg", 32'h1b, rd)
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w, rd);
      bus(1'b0, rows[i].a, 8'h0, rd);
      `CHK("readback", {24'h0, rows[i].r}, rd)
    end
    #1;
    `CHK("memPreset", 6'h2a, memRail.preset)
    `CHK("memCode", 6'h2b, memRail.code)
    `CHK("memOn", 1'b1, memRail.on)
    `CHK("periCode", 5'h1e, periRail.code)
    `CHK("periHalf", 1'b1, periRail.halfSize)
    `CHK("periOn", 1'b0, periRail.on)
    // mode 0 memory write must wait for go, then step
    @(posedge mclk);
    bus(1'b1, 32'hc0, 8'h6d, rd);
    repeat (3) @(posedge mclk);
    `CHK("memCode", 6'h2b, memRail.code)
    pulse(0);
    `CHK("ramping", 1'b1, memRail.ramping)
    `CHK("memCode", 6'h2b, memRail.code)
    k = 0;
    while (memRail.code !== 6'h2d && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    `CHK("rampTime", 2 * (RAMP_STEP_CYC + 1), k)
    repeat (3) @(posedge mclk);
    #1;
    `CHK("ramping", 1'b0, memRail.ramping)
    `CHK("memCode", 6'h2d, memRail.code)
    // a go with nothing pending leaves the rail alone
    pulse(0);
    `CHK("idleGo", 1'b0, memRail.ramping)
    // peripheral preset taken at power-down instead of switching off
    @(posedge mclk);
    bus(1'b1, 32'hc4, 8'h85, rd);
    #1;
    `CHK("periCode", 5'h1e, periRail.code)
    `CHK("periPreset", 5'h05, periRail.preset)
    pulse(1);
    `CHK("periOn", 1'b1, periRail.on)
    @(posedge mclk);
    bus(1'b0, 32'hc4, 8'h0, rd);
    `CHK("periReg", 32'hc5, rd)
    pulse(2);
    `CHK("periCode", 5'h05, periRail.code)
    `CHK("periOn", 1'b1, periRail.on)
    @(posedge mclk);
    bus(1'b1, 32'hc4, 8'h10, rd);
    #1;
    `CHK("periCode", 5'h10, periRail.code)
    pulse(2);
    `CHK("periOn", 1'b0, periRail.on)
    @(posedge mclk);
    bus(1'b0, 32'hc8, 8'h0, rd);
    `CHK("status", 32'h08, rd)
    `CHK("hresp", 1'b0, hresp)
    // clock enable low: bus stalls and sequencer pulses are ignored
    @(posedge mclk);
    ce <= 1'h0;
    periPowerUp <= 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("ceReady", 1'b0, hreadyout)
    `CHK("ceOn", 1'b0, periRail.on)
    @(posedge mclk);
    ce <= 1'h1;
    periPowerUp <= 1'h0;
    // second reset in mid-run
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK("periCode", 5'h1b, periRail.code)
    `CHK("memCode", 6'h2b, memRail.code)
    `CHK("memOn", 1'b0, memRail.on)
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 32'hc4, 8'h0, rd);
    `CHK("periReg", 32'h1b, rd)
    finish_test();
  end
endmodule : tb_brs_rail_regs
`undef CHK
`default_nettype wire
